/* File: inc/iap_unlock_pkg.sv */
/*
 Constants for the program-memory unlock and factory option decode block.
 Assumes an 8-bit special-function register port and a 16-bit processor write bus.
*/
package iap_unlock_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0]  UNLOCK_PATTERN_ADDR = 8'hfb;
   localparam logic [7:0]  OPTION_READ_ADDR    = 8'hfc;
   localparam logic [7:0]  STATUS_READ_ADDR    = 8'hfd;
   // ==========================================================
   // Unlock bytes
   localparam logic [7:0]  UNLOCK_FIRST        = 8'h46;
   localparam logic [7:0]  UNLOCK_SECOND       = 8'hb9;
   // ==========================================================
   // Programmable region
   localparam logic [15:0] PROG_REGION_LO      = 16'he000;
   localparam logic [15:0] PROG_REGION_HI      = 16'hffff;
   // ==========================================================
   // Option word fields
   localparam int          OPT_DIV_HI          = 6;
   localparam int          OPT_DIV_LO          = 5;
   localparam int          OPT_DUMP            = 4;
   localparam int          OPT_WDT             = 2;
   localparam int          OPT_SLOW_SRC        = 1;
   localparam int          OPT_RTC_DIS         = 0;
   localparam logic [1:0]  DIV_SEL_1           = 2'h0;
   localparam logic [1:0]  DIV_SEL_8           = 2'h1;
   localparam logic [1:0]  DIV_SEL_2           = 2'h2;
   localparam logic [1:0]  DIV_SEL_4           = 2'h3;
   localparam logic [3:0]  DIV_BY_1            = 4'h1;
   localparam logic [3:0]  DIV_BY_2            = 4'h2;
   localparam logic [3:0]  DIV_BY_4            = 4'h4;
   localparam logic [3:0]  DIV_BY_8            = 4'h8;
   localparam logic [7:0]  OPTION_USED_MASK    = 8'h77;
   // ==========================================================
   // Unlock sequence states
   typedef enum logic [2:0] {
      ST_LOCKED = 3'b001,
      ST_HALF   = 3'b010,
      ST_OPEN   = 3'b100
   } unlock_state_t;
endpackage : iap_unlock_pkg

/* File: rtl/iap_unlock.sv */
/*
 Program-memory write unlock and factory option word decode.
 Holds the two-byte unlock sequence, the registered program write strobe,
 the option word decode and a small register read port.
 Assumes the core presents one-cycle register strobes and a one-cycle memory
 write strobe with its address, all on this clock.
 Assumes the programming-voltage pin is asynchronous and idles high.
 Assumes the option word is static once the part is out of reset.
 A repeated first byte abandons the sequence; firmware starts again from 46h.
*/
// The implementer's own choice: strobed register access.
// How it works
// - Memory write allowed only after pattern register gets 46h then B9h.
// - Permission drops on next core write or falling programming-voltage edge.
// - Unlocked stores land only in E000h to FFFFh.
// - Option bits 6:5 pick divider: 00 /1, 01 /8, 10 /2, 11 /4.
// - Option bit 4 zero blocks code dump; one allows it.
// - Option bit 2 zero disables watchdog; one enables it.
// - Option bit 1 zero uses external crystal pins; one uses internal oscillator.
// - Option bit 0 zero enables RTC and keeps crystal running; one disables RTC.
module iap_unlock #(
   parameter int REG_AW = 8,
   parameter int REG_DW = 8,
   parameter int MEM_AW = 16
) (
   input  wire logic              CLOCK,
   input  wire logic              RESETN,
   input  wire logic [REG_AW-1:0] ADDR,
   input  wire logic [REG_DW-1:0] WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic      [REG_DW-1:0] RDATA,
   input  wire logic              MEM_WR,
   input  wire logic [MEM_AW-1:0] MEM_ADDR,
   input  wire logic              VPP_PIN,
   input  wire logic [7:0]        OPTION_WORD,
   output logic                   PROG_WRITE,
   output logic      [3:0]        MAIN_CLOCK_DIV,
   output logic                   DUMP_ALLOW,
   output logic                   WDT_ENABLE,
   output logic                   SLOW_INTERNAL,
   output logic                   XTAL_PINS_EN,
   output logic                   RTC_ENABLE,
   output logic                   XTAL_ALWAYS_ON
);
   // ==========================================================
   // Pin synchroniser, three stages
   logic [2:0] vpp_sync_ff;
   logic       vpp_level_ff;
   logic       nxt_vpp_level;
   logic       vpp_fall;
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         vpp_sync_ff <= 3'h0;
      end else begin
         vpp_sync_ff <= {vpp_sync_ff[1:0], VPP_PIN};
      end
   end
   // Change counted only when stages two and three agree
   always_comb begin
      nxt_vpp_level = vpp_level_ff;
      if (vpp_sync_ff[1] == vpp_sync_ff[2]) begin
         nxt_vpp_level = vpp_sync_ff[2];
      end
   end
   // Starts low, so a release with the pin high gives a rise, never a false fall
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         vpp_level_ff <= 1'b0;
      end else begin
         vpp_level_ff <= nxt_vpp_level;
      end
   end
   // Look-ahead, so a store in the cycle of the fall is refused as well
   assign vpp_fall = vpp_level_ff && !nxt_vpp_level;
   // ==========================================================
   // Unlock sequence
   iap_unlock_pkg::unlock_state_t state_ff;
   iap_unlock_pkg::unlock_state_t nxt_state;
   logic                          pattern_wr;
   logic                          first_byte;
   logic                          second_byte;
   logic                          core_write;
   assign pattern_wr  = WR && (ADDR == REG_AW'(iap_unlock_pkg::UNLOCK_PATTERN_ADDR));
   assign first_byte  = pattern_wr && (WDATA == REG_DW'(iap_unlock_pkg::UNLOCK_FIRST));
   assign second_byte = pattern_wr && (WDATA == REG_DW'(iap_unlock_pkg::UNLOCK_SECOND));
   // Register and memory stores both count as a core write action
   assign core_write  = WR || MEM_WR;
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         iap_unlock_pkg::ST_LOCKED: begin
            if (first_byte) begin
               nxt_state = iap_unlock_pkg::ST_HALF;
            end
         end
         iap_unlock_pkg::ST_HALF: begin
            if (second_byte) begin
               nxt_state = iap_unlock_pkg::ST_OPEN;
            end else if (core_write) begin
               // Any other write breaks the pair
               nxt_state = iap_unlock_pkg::ST_LOCKED;
            end
         end
         iap_unlock_pkg::ST_OPEN: begin
            // Next core write of any kind closes the window
            if (core_write) begin
               nxt_state = iap_unlock_pkg::ST_LOCKED;
            end
         end
         default: nxt_state = iap_unlock_pkg::ST_LOCKED;
      endcase
      if (vpp_fall) begin
         nxt_state = iap_unlock_pkg::ST_LOCKED;
      end
   end
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         state_ff <= iap_unlock_pkg::ST_LOCKED;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // ==========================================================
   // Program write strobe, one cycle after the store it permits
   logic in_region;
   logic prog_ok;
   assign in_region = (MEM_ADDR >= MEM_AW'(iap_unlock_pkg::PROG_REGION_LO)) &&
                      (MEM_ADDR <= MEM_AW'(iap_unlock_pkg::PROG_REGION_HI));
   // A store outside the region gets no pulse but still relocks
   assign prog_ok = MEM_WR && in_region && !vpp_fall &&
                    (state_ff == iap_unlock_pkg::ST_OPEN);
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         PROG_WRITE <= 1'b0;
      end else begin
         PROG_WRITE <= prog_ok;
      end
   end
   // ==========================================================
   // Option decode; the word is static after power-up, so no synchroniser
   logic [1:0] div_sel;
   logic [3:0] nxt_div;
   assign div_sel = {OPTION_WORD[iap_unlock_pkg::OPT_DIV_HI],
                     OPTION_WORD[iap_unlock_pkg::OPT_DIV_LO]};
   always_comb begin
      case (div_sel)
         iap_unlock_pkg::DIV_SEL_1: nxt_div = iap_unlock_pkg::DIV_BY_1;
         iap_unlock_pkg::DIV_SEL_8: nxt_div = iap_unlock_pkg::DIV_BY_8;
         iap_unlock_pkg::DIV_SEL_2: nxt_div = iap_unlock_pkg::DIV_BY_2;
         iap_unlock_pkg::DIV_SEL_4: nxt_div = iap_unlock_pkg::DIV_BY_4;
         default:                   nxt_div = iap_unlock_pkg::DIV_BY_1;
      endcase
   end
   // Reset shows the safest settings: divide by one, dump locked, watchdog on
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         MAIN_CLOCK_DIV <= iap_unlock_pkg::DIV_BY_1;
      end else begin
         MAIN_CLOCK_DIV <= nxt_div;
      end
   end
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         DUMP_ALLOW <= 1'b0;
      end else begin
         DUMP_ALLOW <= OPTION_WORD[iap_unlock_pkg::OPT_DUMP];
      end
   end
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         WDT_ENABLE <= 1'b1;
      end else begin
         WDT_ENABLE <= OPTION_WORD[iap_unlock_pkg::OPT_WDT];
      end
   end
   // The pins go to the crystal only while the internal source is off
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         SLOW_INTERNAL <= 1'b1;
         XTAL_PINS_EN  <= 1'b0;
      end else begin
         SLOW_INTERNAL <= OPTION_WORD[iap_unlock_pkg::OPT_SLOW_SRC];
         XTAL_PINS_EN  <= !OPTION_WORD[iap_unlock_pkg::OPT_SLOW_SRC];
      end
   end
   // The crystal runs whenever the RTC is enabled
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         RTC_ENABLE     <= 1'b0;
         XTAL_ALWAYS_ON <= 1'b0;
      end else begin
         RTC_ENABLE     <= !OPTION_WORD[iap_unlock_pkg::OPT_RTC_DIS];
         XTAL_ALWAYS_ON <= !OPTION_WORD[iap_unlock_pkg::OPT_RTC_DIS];
      end
   end
   // ==========================================================
   // Read port; pattern register itself is write-only
   logic [REG_DW-1:0] nxt_rdata;
   always_comb begin
      nxt_rdata = '0;
      if (RD) begin
         case (ADDR)
            REG_AW'(iap_unlock_pkg::OPTION_READ_ADDR): begin
               nxt_rdata = REG_DW'(OPTION_WORD & iap_unlock_pkg::OPTION_USED_MASK);
            end
            // Status shows the one-hot state, so a half-done unlock is visible
            REG_AW'(iap_unlock_pkg::STATUS_READ_ADDR): begin
               nxt_rdata = REG_DW'(state_ff);
            end
            // Unmapped and write-only addresses read as zero
            default: nxt_rdata = '0;
         endcase
      end
   end
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= '0;
      end else begin
         RDATA <= nxt_rdata;
      end
   end
endmodule : iap_unlock

/* File: tb/iap_unlock_chk.sv */
/* Checker for the unlock path and the option decode outputs other than XTAL_PINS_EN and XTAL_ALWAYS_ON.
   Assumes it is bound onto the block and that the option word moves slowly. */
module iap_unlock_chk (
   input wire logic        CLOCK,
   input wire logic        RESETN,
   input wire logic [7:0]  ADDR,
   input wire logic [7:0]  WDATA,
   input wire logic        WR,
   input wire logic        MEM_WR,
   input wire logic [15:0] MEM_ADDR,
   input wire logic [7:0]  OPTION_WORD,
   input wire logic        PROG_WRITE,
   input wire logic [3:0]  MAIN_CLOCK_DIV,
   input wire logic        DUMP_ALLOW,
   input wire logic        WDT_ENABLE,
   input wire logic        SLOW_INTERNAL,
   input wire logic        RTC_ENABLE
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Sequences
   logic [7:0] opt_ff;
   always_ff @(posedge CLOCK) opt_ff <= OPTION_WORD;
   default clocking dcb @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   sequence s_pat(logic [7:0] v);
      WR && ADDR == iap_unlock_pkg::UNLOCK_PATTERN_ADDR && WDATA == v;
   endsequence
   sequence s_store;
      MEM_WR && MEM_ADDR >= iap_unlock_pkg::PROG_REGION_LO;
   endsequence
   // ==========================================================
   // Properties
   open_store_a: assert property (s_pat(8'h46) ##1 s_pat(8'hb9) ##1 s_store
      |=> PROG_WRITE) else $error("unlocked store not written");
   range_only_a: assert property (PROG_WRITE |->
      $past(MEM_WR) && $past(MEM_ADDR) >= 16'he000) else $error("write outside region");
   relock_a: assert property (MEM_WR ##1 MEM_WR |=> !PROG_WRITE)
      else $error("second store written");
   abort_a: assert property (s_pat(8'h46) ##1 (WR && WDATA != 8'hb9) ##1 MEM_WR
      |=> !PROG_WRITE) else $error("store after wrong byte");
   div_map_a: assert property ($past(RESETN) |->
      MAIN_CLOCK_DIV == 4'h1 << {opt_ff[5], opt_ff[6] ^ opt_ff[5]}) else $error("divider");
   dump_lock_a: assert property ($past(RESETN) |-> DUMP_ALLOW == opt_ff[4])
      else $error("dump lock");
   wdt_gate_a: assert property ($past(RESETN) |-> WDT_ENABLE == opt_ff[2])
      else $error("watchdog gate");
   slow_rtc_a: assert property ($past(RESETN) |->
      SLOW_INTERNAL == opt_ff[1] && RTC_ENABLE != opt_ff[0]) else $error("slow clock or rtc");
endmodule : iap_unlock_chk

bind iap_unlock iap_unlock_chk chk_u (.*);

/* File: tb/iap_unlock_tb_top.sv */
/* Testbench: drives register port, core stores, programming pin and option word.
   Assumes the checker binds itself onto the block. */
module iap_unlock_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLOCK = 1'b0, RESETN = 1'b0, WR = 1'b0, RD = 1'b0, MEM_WR = 1'b0;
   logic        VPP_PIN = 1'b1, PROG_WRITE, DUMP_ALLOW, WDT_ENABLE, SLOW_INTERNAL;
   logic        XTAL_PINS_EN, RTC_ENABLE, XTAL_ALWAYS_ON, pend = 1'b0;
   logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, OPTION_WORD = 8'h00, RDATA;
   logic [15:0] MEM_ADDR = 16'h0000;
   logic [3:0]  MAIN_CLOCK_DIV;
   logic [18:0] exp_q[$];
   int          bad_count = 0, total_checks = 0;
   wire  [18:0] seen = {PROG_WRITE, RDATA, MAIN_CLOCK_DIV, DUMP_ALLOW, WDT_ENABLE,
                        SLOW_INTERNAL, XTAL_PINS_EN, RTC_ENABLE, XTAL_ALWAYS_ON};
   iap_unlock dut_u (.*);
   always #2 CLOCK = ~CLOCK;
   // ==========================================================
   // Helpers
   function automatic logic [9:0] dec(input logic [7:0] o);
      return {4'h1 << {o[5], o[6] ^ o[5]}, o[4], o[2], o[1], !o[1], !o[0], !o[0]};
   endfunction : dec
   task automatic check(input string n, input logic [18:0] e, input logic [18:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic op(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d,
                     input logic [15:0] ma, input logic [8:0] e);
      {WR, RD, MEM_WR} <= k;
      ADDR <= a;
      WDATA <= d;
      MEM_ADDR <= ma;
      if (k[1] || k[0])
         exp_q.push_back({e, dec(OPTION_WORD)});
      @(posedge CLOCK);
   endtask : op
   task automatic unlock();
      op(3'b100, 8'hfb, 8'h46, 16'h0000, 9'h000);
      op(3'b100, 8'hfb, 8'hb9, 16'h0000, 9'h000);
   endtask : unlock
   task automatic final_report();
      check("leftover", 19'h00000, 19'(exp_q.size()));
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   // Result appears one cycle after the strobe, so compare on the edge after that
   always @(posedge CLOCK) begin
      if (pend)
         check("result", exp_q.pop_front(), seen);
      pend <= RESETN && (RD || MEM_WR);
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] o;
      void'($urandom(90));
      repeat (10) @(posedge CLOCK);
      check("reset", 19'h00058, seen);
      RESETN <= 1'b1;
      @(posedge CLOCK);
      for (int i = 0; i < 4; i++) begin
         o = 8'($urandom);
         o[6:5] = 2'(i);
         o[4:0] = {i[0], o[3], !i[0], i[1], !i[1]};
         OPTION_WORD <= o;
         op(3'b100, 8'h10, 8'($urandom), 16'h0000, 9'h000);
         op(3'b000, 8'h00, 8'h00, 16'h0000, 9'h000);
         op(3'b010, 8'hfc, 8'h00, 16'h0000, {1'b0, o & 8'h77});
      end
      unlock();
      op(3'b001, 8'h00, 8'h00, 16'he000, 9'h100);
      op(3'b001, 8'h00, 8'h00, 16'he000, 9'h000);
      unlock();
      op(3'b001, 8'h00, 8'h00, 16'hffff, 9'h100);
      unlock();
      op(3'b001, 8'h00, 8'h00, 16'hdfff, 9'h000);
      op(3'b001, 8'h00, 8'h00, 16'he000, 9'h000);
      op(3'b100, 8'hfb, 8'h46, 16'h0000, 9'h000);
      op(3'b100, 8'hfb, 8'h47, 16'h0000, 9'h000);
      op(3'b001, 8'h00, 8'h00, 16'he000, 9'h000);
      op(3'b100, 8'hfb, 8'h46, 16'h0000, 9'h000);
      op(3'b010, 8'hfd, 8'h00, 16'h0000, 9'h002);
      op(3'b100, 8'hfb, 8'hb9, 16'h0000, 9'h000);
      op(3'b010, 8'hfd, 8'h00, 16'h0000, 9'h004);
      op(3'b100, 8'h10, 8'($urandom), 16'h0000, 9'h000);
      op(3'b001, 8'h00, 8'h00, 16'he000, 9'h000);
      op(3'b100, 8'hfb, 8'hb9, 16'h0000, 9'h000);
      op(3'b100, 8'hfb, 8'h46, 16'h0000, 9'h000);
      op(3'b001, 8'h00, 8'h00, 16'he000, 9'h000);
      unlock();
      RESETN <= 1'b0;
      repeat (2) op(3'b000, 8'h00, 8'h00, 16'h0000, 9'h000);
      check("reset", 19'h00058, seen);
      RESETN <= 1'b1;
      repeat (2) op(3'b000, 8'h00, 8'h00, 16'h0000, 9'h000);
      op(3'b001, 8'h00, 8'h00, 16'he000, 9'h000);
      unlock();
      VPP_PIN <= 1'b0;
      repeat (4) op(3'b000, 8'h00, 8'h00, 16'h0000, 9'h000);
      op(3'b001, 8'h00, 8'h00, 16'he000, 9'h000);
      VPP_PIN <= 1'b1;
      op(3'b010, 8'h10, 8'h00, 16'h0000, 9'h000);
      op(3'b010, 8'hfb, 8'h00, 16'h0000, 9'h000);
      repeat (3) op(3'b000, 8'h00, 8'h00, 16'h0000, 9'h000);
      final_report();
   end
endmodule : iap_unlock_tb_top
